/* File: rtl/abx_pkg.sv */
package abx_pkg;

    // ------------------------------------------------------------
    // opcodes and reg-field selectors
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ADD_ACC_B = 8'h04;
    localparam logic [7:0] OP_AND_ACC_B = 8'h24;
    localparam logic [7:0] OP_AND_ACC_W = 8'h25;
    localparam logic [7:0] OP_GRP_B = 8'h80;
    localparam logic [7:0] OP_GRP_W = 8'h81;
    localparam logic [7:0] OP_GRP_SX = 8'h83;
    localparam logic [7:0] OP_AND_RM_B = 8'h20;
    localparam logic [7:0] OP_AND_RM_W = 8'h21;
    localparam logic [7:0] OP_AND_R_B = 8'h22;
    localparam logic [7:0] OP_AND_R_W = 8'h23;
    localparam logic [7:0] OP_BOUND = 8'h62;
    localparam logic [2:0] REGF_ADD = 3'h0;
    localparam logic [2:0] REGF_AND = 3'h4;
    localparam logic [1:0] MOD_REG = 2'h3;
    localparam int MODRM_MOD_HI = 7;
    localparam int MODRM_MOD_LO = 6;
    localparam int MODRM_REG_HI = 5;
    localparam int MODRM_REG_LO = 3;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [15:0] SEXT_NEG = 16'hFF00;
    localparam logic [15:0] SEXT_POS = 16'h00FF;
    localparam logic [7:0] BOUND_VECTOR = 8'h05;
    localparam logic [15:0] BOUND_HI_OFS = 16'h0002;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ------------------------------------------------------------
    // execution lengths in core clocks
    // ------------------------------------------------------------
    localparam logic [5:0] CYC_ACC_B = 6'h03;
    localparam logic [5:0] CYC_ACC_W = 6'h04;
    localparam logic [5:0] CYC_RR = 6'h03;
    localparam logic [5:0] CYC_RM16 = 6'h0A;
    localparam logic [5:0] CYC_RM8B = 6'h0E;
    localparam logic [5:0] CYC_IR = 6'h04;
    localparam logic [5:0] CYC_IM16 = 6'h10;
    localparam logic [5:0] CYC_IM8B = 6'h14;
    localparam logic [5:0] CYC_BOUND = 6'h21;
    localparam logic [5:0] CYC_BOUND_MAX = 6'h23;
    localparam logic [5:0] CNT_MAX = 6'h3F;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD_LO = 3'h1,
        ST_RD_HI = 3'h3,
        ST_EXEC = 3'h2,
        ST_WR = 3'h6,
        ST_FIN = 3'h7
    } abx_state_t;

    typedef enum logic [1:0] {
        DST_NONE = 2'h0,
        DST_ACC = 2'h1,
        DST_REG = 2'h2,
        DST_RM = 2'h3
    } abx_dst_t;

    function automatic logic [15:0] abx_sext8(input logic [7:0] b);
        if (b[7]) begin
            return SEXT_NEG | {8'h00, b};
        end
        return SEXT_POS & {8'h00, b};
    endfunction

    function automatic logic abx_even_parity(input logic [7:0] b);
        return ~^b;
    endfunction

endpackage

/* File: rtl/abx_alu_if.sv */
interface abx_alu_if;
    logic op_and;
    logic word;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] res;
    logic carry_flag;
    logic overflow_flag;
    logic aux_carry_flag;
    logic zero_flag;
    logic sign_flag;
    logic parity_flag;
    logic out_of_range;

    modport core (output op_and, word, a, b, lo, hi,
                  input res, carry_flag, overflow_flag, aux_carry_flag,
                  zero_flag, sign_flag, parity_flag, out_of_range);
    modport alu (input op_and, word, a, b, lo, hi,
                 output res, carry_flag, overflow_flag, aux_carry_flag,
                 zero_flag, sign_flag, parity_flag, out_of_range);
endinterface

/* File: rtl/abx_alu.sv */
module abx_alu (
    abx_alu_if.alu p
);
    logic [16:0] sum;
    logic [15:0] raw;

    // ------------------------------------------------------------
    // add or and, byte results keep the upper byte clear
    // ------------------------------------------------------------
    always_comb begin
        sum = {1'b0, p.a} + {1'b0, p.b};
        raw = p.op_and ? (p.a & p.b) : sum[15:0];
        p.res = p.word ? raw : {8'h00, raw[7:0]};
        if (p.op_and) begin
            p.carry_flag = 1'b0;
            p.overflow_flag = 1'b0;
            p.aux_carry_flag = 1'b0;
        end else begin
            p.carry_flag = p.word ? sum[16] : (p.a[8] ^ p.b[8] ^ sum[8]);
            if (p.word) begin
                p.overflow_flag = (p.a[15] == p.b[15]) &&
                                  (sum[15] != p.a[15]);
            end else begin
                p.overflow_flag = (p.a[7] == p.b[7]) && (sum[7] != p.a[7]);
            end
            // carry out of the low nibble tells the decimal adjust step
            p.aux_carry_flag = p.a[4] ^ p.b[4] ^ sum[4];
        end
        p.zero_flag = (p.res == abx_pkg::RESET_WORD);
        p.sign_flag = p.word ? p.res[15] : p.res[7];
        p.parity_flag = abx_pkg::abx_even_parity(p.res[7:0]);
        p.out_of_range = ($signed(p.a) < $signed(p.lo)) ||
                         ($signed(p.a) > $signed(p.hi));
    end

endmodule

/* File: rtl/abx_exec.sv */
module abx_exec (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic START,
    input wire logic [7:0] OPCODE,
    input wire logic [7:0] MODRM,
    input wire logic [15:0] IMM,
    input wire logic [15:0] ACC_VAL,
    input wire logic [15:0] REG_VAL,
    input wire logic [15:0] RM_VAL,
    input wire logic [15:0] EFF_ADDR,
    input wire logic [15:0] INSTR_PTR,
    input wire logic BUS8,
    input wire logic [15:0] MEM_RDATA,
    input wire logic MEM_ACK,
    output logic BUSY,
    output logic DONE,
    output logic BAD_OP,
    output logic [15:0] RESULT,
    output logic RESULT_WORD,
    output logic REG_WE,
    output logic [1:0] REG_SEL,
    output logic FLAG_WE,
    output logic CARRY_FLAG,
    output logic OVERFLOW_FLAG,
    output logic AUX_CARRY_FLAG,
    output logic ZERO_FLAG,
    output logic SIGN_FLAG,
    output logic PARITY_FLAG,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic MEM_WORD,
    output logic [15:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    output logic EXC_REQ,
    output logic [7:0] EXC_VECTOR,
    output logic [15:0] EXC_INSTR_PTR
);
    abx_pkg::abx_state_t st_q;
    abx_pkg::abx_dst_t dc_dst;
    abx_pkg::abx_dst_t dst_q;
    logic bus8_s1_q, bus8_s2_q;
    logic dc_ok, dc_and, dc_word, dc_bound, dc_rm, dc_rm_first, dc_mem;
    logic [5:0] dc_cyc;
    logic [15:0] dc_a, dc_b;
    logic [2:0] regf;
    logic ok_q, and_q, word_q, bound_q, mem_q, rm_first_q, sx_q;
    logic [5:0] cyc_q, cnt_q;
    logic [15:0] a_q, b_q, lo_q, hi_q, ea_q, ip_q, res_q;
    logic fire;
    abx_alu_if alu_bus ();

    abx_alu u_alu (
        .p(alu_bus)
    );

    // ------------------------------------------------------------
    // strap-like pin, two stages before use
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bus8_s1_q <= 1'b0;
            bus8_s2_q <= 1'b0;
        end else begin
            bus8_s1_q <= BUS8;
            bus8_s2_q <= bus8_s1_q;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign regf = MODRM[abx_pkg::MODRM_REG_HI:abx_pkg::MODRM_REG_LO];
    assign dc_mem = dc_rm &&
        (MODRM[abx_pkg::MODRM_MOD_HI:abx_pkg::MODRM_MOD_LO] !=
         abx_pkg::MOD_REG);

    always_comb begin
        dc_ok = 1'b1;
        dc_and = 1'b1;
        dc_word = OPCODE[0];
        dc_bound = 1'b0;
        dc_rm = 1'b1;
        dc_rm_first = 1'b1;
        dc_dst = abx_pkg::DST_RM;
        dc_a = RM_VAL;
        dc_b = REG_VAL;
        dc_cyc = abx_pkg::CYC_RR;
        case (OPCODE)
            abx_pkg::OP_ADD_ACC_B, abx_pkg::OP_AND_ACC_B,
            abx_pkg::OP_AND_ACC_W: begin
                dc_and = (OPCODE != abx_pkg::OP_ADD_ACC_B);
                dc_rm = 1'b0;
                dc_dst = abx_pkg::DST_ACC;
                dc_a = ACC_VAL;
                dc_b = dc_word ? IMM : {8'h00, IMM[7:0]};
                dc_cyc = dc_word ? abx_pkg::CYC_ACC_W : abx_pkg::CYC_ACC_B;
            end
            abx_pkg::OP_GRP_B, abx_pkg::OP_GRP_W, abx_pkg::OP_GRP_SX: begin
                dc_ok = (regf == abx_pkg::REGF_ADD) ||
                        (regf == abx_pkg::REGF_AND);
                dc_and = (regf == abx_pkg::REGF_AND);
                dc_word = (OPCODE != abx_pkg::OP_GRP_B);
                if (OPCODE == abx_pkg::OP_GRP_SX) begin
                    dc_b = abx_pkg::abx_sext8(IMM[7:0]);
                end else begin
                    dc_b = dc_word ? IMM : {8'h00, IMM[7:0]};
                end
                if (!dc_mem) begin
                    dc_cyc = abx_pkg::CYC_IR;
                end else if (dc_word && bus8_s2_q) begin
                    dc_cyc = abx_pkg::CYC_IM8B;
                end else begin
                    dc_cyc = abx_pkg::CYC_IM16;
                end
            end
            abx_pkg::OP_AND_RM_B, abx_pkg::OP_AND_RM_W,
            abx_pkg::OP_AND_R_B, abx_pkg::OP_AND_R_W: begin
                if (OPCODE[1]) begin
                    dc_rm_first = 1'b0;
                    dc_dst = abx_pkg::DST_REG;
                    dc_a = REG_VAL;
                    dc_b = RM_VAL;
                end
                if (!dc_mem) begin
                    dc_cyc = abx_pkg::CYC_RR;
                end else if (dc_word && bus8_s2_q) begin
                    dc_cyc = abx_pkg::CYC_RM8B;
                end else begin
                    dc_cyc = abx_pkg::CYC_RM16;
                end
            end
            abx_pkg::OP_BOUND: begin
                dc_ok = dc_mem;
                dc_bound = 1'b1;
                dc_word = 1'b1;
                dc_dst = abx_pkg::DST_NONE;
                dc_a = REG_VAL;
                dc_cyc = abx_pkg::CYC_BOUND;
            end
            default: begin
                dc_ok = 1'b0;
                dc_dst = abx_pkg::DST_NONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    // done waits for the count, so memory waits stretch the length only when FIN comes after the count
    assign fire = (st_q == abx_pkg::ST_FIN) && (cnt_q >= cyc_q);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_q <= abx_pkg::ST_IDLE;
        end else begin
            case (st_q)
                abx_pkg::ST_IDLE: begin
                    if (START) begin
                        if (!dc_ok) begin
                            st_q <= abx_pkg::ST_FIN;
                        end else if (dc_mem) begin
                            st_q <= abx_pkg::ST_RD_LO;
                        end else begin
                            st_q <= abx_pkg::ST_EXEC;
                        end
                    end
                end
                abx_pkg::ST_RD_LO: begin
                    if (MEM_ACK) begin
                        st_q <= bound_q ? abx_pkg::ST_RD_HI :
                                          abx_pkg::ST_EXEC;
                    end
                end
                abx_pkg::ST_RD_HI: begin
                    if (MEM_ACK) begin
                        st_q <= abx_pkg::ST_EXEC;
                    end
                end
                abx_pkg::ST_EXEC: begin
                    if (mem_q && dst_q == abx_pkg::DST_RM) begin
                        st_q <= abx_pkg::ST_WR;
                    end else begin
                        st_q <= abx_pkg::ST_FIN;
                    end
                end
                abx_pkg::ST_WR: begin
                    if (MEM_ACK) begin
                        st_q <= abx_pkg::ST_FIN;
                    end
                end
                abx_pkg::ST_FIN: begin
                    if (fire) begin
                        st_q <= abx_pkg::ST_IDLE;
                    end
                end
                default: st_q <= abx_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= 6'h00;
        end else if (st_q == abx_pkg::ST_IDLE && START) begin
            cnt_q <= 6'h01;
        end else if (st_q != abx_pkg::ST_IDLE && cnt_q != abx_pkg::CNT_MAX
                     && !fire) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // operands
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ok_q <= 1'b0;
            and_q <= 1'b0;
            word_q <= 1'b0;
            bound_q <= 1'b0;
            mem_q <= 1'b0;
            rm_first_q <= 1'b0;
            sx_q <= 1'b0;
            dst_q <= abx_pkg::DST_NONE;
            cyc_q <= abx_pkg::CYC_RR;
            a_q <= abx_pkg::RESET_WORD;
            b_q <= abx_pkg::RESET_WORD;
            lo_q <= abx_pkg::RESET_WORD;
            hi_q <= abx_pkg::RESET_WORD;
            ea_q <= abx_pkg::RESET_WORD;
            ip_q <= abx_pkg::RESET_WORD;
        end else if (st_q == abx_pkg::ST_IDLE && START) begin
            ok_q <= dc_ok;
            and_q <= dc_and;
            word_q <= dc_word;
            bound_q <= dc_bound;
            mem_q <= dc_mem;
            rm_first_q <= dc_rm_first;
            sx_q <= (OPCODE == abx_pkg::OP_GRP_SX);
            dst_q <= dc_dst;
            cyc_q <= dc_cyc;
            a_q <= dc_a;
            b_q <= dc_b;
            ea_q <= EFF_ADDR;
            ip_q <= INSTR_PTR;
        end else if (MEM_ACK && st_q == abx_pkg::ST_RD_LO) begin
            if (bound_q) begin
                lo_q <= MEM_RDATA;
            end else if (rm_first_q) begin
                a_q <= MEM_RDATA;
            end else begin
                b_q <= MEM_RDATA;
            end
        end else if (MEM_ACK && st_q == abx_pkg::ST_RD_HI) begin
            hi_q <= MEM_RDATA;
        end
    end

    always_comb begin
        alu_bus.op_and = and_q;
        alu_bus.word = word_q;
        alu_bus.a = a_q;
        alu_bus.b = b_q;
        alu_bus.lo = lo_q;
        alu_bus.hi = hi_q;
    end

    // ------------------------------------------------------------
    // memory port
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            MEM_WORD <= 1'b0;
            MEM_ADDR <= abx_pkg::RESET_WORD;
            MEM_WDATA <= abx_pkg::RESET_WORD;
        end else if (st_q == abx_pkg::ST_IDLE && START && dc_ok && dc_mem) begin
            MEM_RD <= 1'b1;
            MEM_WORD <= dc_word;
            MEM_ADDR <= EFF_ADDR;
        end else if (st_q == abx_pkg::ST_RD_LO && MEM_ACK && bound_q) begin
            MEM_ADDR <= ea_q + abx_pkg::BOUND_HI_OFS;
        end else if (st_q == abx_pkg::ST_EXEC && mem_q &&
                     dst_q == abx_pkg::DST_RM) begin
            MEM_WR <= 1'b1;
            MEM_ADDR <= ea_q;
            MEM_WDATA <= alu_bus.res;
        end else if (MEM_ACK) begin
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // results and exception shown with done, flags already from the clock after execute
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            res_q <= abx_pkg::RESET_WORD;
            CARRY_FLAG <= 1'b0;
            OVERFLOW_FLAG <= 1'b0;
            AUX_CARRY_FLAG <= 1'b0;
            ZERO_FLAG <= 1'b0;
            SIGN_FLAG <= 1'b0;
            PARITY_FLAG <= 1'b0;
            EXC_REQ <= 1'b0;
        end else if (st_q == abx_pkg::ST_EXEC) begin
            res_q <= alu_bus.res;
            CARRY_FLAG <= alu_bus.carry_flag;
            OVERFLOW_FLAG <= alu_bus.overflow_flag;
            AUX_CARRY_FLAG <= alu_bus.aux_carry_flag;
            ZERO_FLAG <= alu_bus.zero_flag;
            SIGN_FLAG <= alu_bus.sign_flag;
            PARITY_FLAG <= alu_bus.parity_flag;
            EXC_REQ <= 1'b0;
        end else begin
            EXC_REQ <= fire && ok_q && bound_q &&
                       alu_bus.out_of_range;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
            BAD_OP <= 1'b0;
            RESULT <= abx_pkg::RESET_WORD;
            RESULT_WORD <= 1'b0;
            REG_WE <= 1'b0;
            REG_SEL <= abx_pkg::DST_NONE;
            FLAG_WE <= 1'b0;
            EXC_VECTOR <= 8'h00;
            EXC_INSTR_PTR <= abx_pkg::RESET_WORD;
        end else begin
            BUSY <= (st_q == abx_pkg::ST_IDLE) ? START : !fire;
            DONE <= fire;
            BAD_OP <= fire && !ok_q;
            RESULT <= fire ? res_q : RESULT;
            RESULT_WORD <= fire ? word_q : RESULT_WORD;
            // an in-range check writes nothing and simply completes
            REG_WE <= fire && ok_q && !bound_q && dst_q != abx_pkg::DST_NONE
                      && !(mem_q && dst_q == abx_pkg::DST_RM);
            REG_SEL <= fire ? dst_q : REG_SEL;
            FLAG_WE <= fire && ok_q && !bound_q;
            EXC_VECTOR <= abx_pkg::BOUND_VECTOR;
            EXC_INSTR_PTR <= fire ? ip_q : EXC_INSTR_PTR;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    chk_sext_word: assert property (
        st_q == abx_pkg::ST_EXEC && sx_q |->
        alu_bus.b[15:8] == (alu_bus.b[7] ? 8'hFF : 8'h00))
        else $error("byte immediate not sign extended");
    chk_add_decode: assert property (
        st_q == abx_pkg::ST_IDLE && START && OPCODE == 8'h04 |=>
        ok_q && !and_q)
        else $error("accumulator add not decoded");
    chk_aux_nibble: assert property (
        st_q == abx_pkg::ST_EXEC && !and_q |=>
        AUX_CARRY_FLAG == (({1'b0, $past(a_q[3:0])} +
                            {1'b0, $past(b_q[3:0])}) > 5'h0F))
        else $error("aux carry not the low nibble carry");
    chk_and_acc: assert property (
        st_q == abx_pkg::ST_IDLE && START && OPCODE == 8'h25 |=>
        and_q && word_q && dst_q == abx_pkg::DST_ACC)
        else $error("accumulator word and not decoded");
    chk_and_result: assert property (
        DONE && FLAG_WE && $past(and_q) && $past(word_q) |->
        RESULT == ($past(a_q, 2) & $past(b_q, 2)))
        else $error("and result wrong");
    chk_and_flags: assert property (
        DONE && FLAG_WE && $past(and_q) |-> !CARRY_FLAG && !OVERFLOW_FLAG)
        else $error("and left carry or overflow set");
    chk_rr_clocks: assert property (
        st_q == abx_pkg::ST_IDLE && START && OPCODE == 8'h23 &&
        MODRM[7:6] == 2'h3 |-> !DONE [*4] ##1 DONE)
        else $error("register and not three clocks");
    chk_ir_clocks: assert property (
        st_q == abx_pkg::ST_IDLE && START && OPCODE == 8'h81 &&
        MODRM[7:6] == 2'h3 && MODRM[5:3] == 3'h4 |-> ##5 DONE)
        else $error("immediate and not four clocks");
    chk_bound_len: assert property (
        DONE && $past(bound_q) && !BAD_OP |-> $past(cnt_q) >= 6'h21)
        else $error("bound check too short");
    chk_bound_addr: assert property (
        st_q == abx_pkg::ST_RD_HI |-> MEM_RD && MEM_ADDR == ea_q + 16'h0002)
        else $error("upper limit address wrong");
    chk_bound_trap: assert property (
        fire && ok_q && bound_q && alu_bus.out_of_range |=>
        EXC_REQ && EXC_VECTOR == 8'h05 && EXC_INSTR_PTR == $past(ip_q))
        else $error("bound exception missing");
    chk_bound_quiet: assert property (
        DONE && $past(bound_q) && !EXC_REQ |-> !REG_WE && !FLAG_WE)
        else $error("in-range bound changed state");
    chk_mem_wb: assert property (
        st_q == abx_pkg::ST_WR |-> MEM_WR && MEM_ADDR == ea_q)
        else $error("write back address wrong");

endmodule

/* File: tb/abx_mem_model.sv */
module abx_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic rd,
    input wire logic wr,
    input wire logic slow,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic ack
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // word memory, acks one or four cycles after a request
    // ------------------------------------------------------------
    logic [15:0] mem [0:255];
    int wait_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            wait_q <= 0;
            rdata <= 16'h0000;
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata; // an idle bus never shows the same word two cycles running
            if ((rd || wr) && !ack && wait_q >= (slow ? 3 : 0)) begin
                ack <= 1'b1;
                wait_q <= 0;
                if (rd) rdata <= mem[addr[8:1]];
                if (wr) mem[addr[8:1]] <= wdata;
            end else if ((rd || wr) && !ack) begin
                wait_q <= wait_q + 1;
            end
        end
    end
endmodule

/* File: tb/add_and_bound_execute_bench.sv */
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    miscompares++; $display("Error at %0t: got %h expected %h", \
    $time, a, b); end end
module add_and_bound_execute_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // random operands with corner cases, expectations from functions
    // ------------------------------------------------------------
    logic ref_clk, rst, start, bus8, slow, done, cf, of, af, rwe, fwe;
    logic mem_rd, mem_wr, mem_ack, exc_req, exc_q, rwe_q, fwe_q, e;
    logic bad, bad_q, zf, sf, pf, rw;
    logic [1:0] sel;
    logic [7:0] opcode, modrm, exc_vector;
    logic [15:0] imm, acc_val, reg_val, rm_val, eff_addr, instr_ptr;
    logic [15:0] result, mem_addr, mem_wdata, mem_rdata, exc_ip, old;
    logic [7:0] ops[9] = '{8'h24, 8'h25, 8'h80, 8'h81, 8'h83, 8'h20,
                           8'h21, 8'h22, 8'h23};
    int cyc[9] = '{3, 4, 4, 4, 4, 3, 3, 3, 3};
    logic [15:0] bidx[6] = '{16'hFEFF, 16'hFF00, 16'h0100, 16'h0101,
                             16'h8000, 16'h0000};
    int miscompares = 0, checks_done = 0, i;
    abx_exec dut_u (.REF_CLK(ref_clk), .RST(rst), .START(start),
        .OPCODE(opcode), .MODRM(modrm), .IMM(imm), .ACC_VAL(acc_val),
        .REG_VAL(reg_val), .RM_VAL(rm_val), .EFF_ADDR(eff_addr),
        .INSTR_PTR(instr_ptr), .BUS8(bus8), .MEM_RDATA(mem_rdata),
        .MEM_ACK(mem_ack), .BUSY(), .DONE(done), .BAD_OP(bad),
        .RESULT(result), .RESULT_WORD(rw), .REG_WE(rwe), .REG_SEL(sel),
        .FLAG_WE(fwe), .CARRY_FLAG(cf), .OVERFLOW_FLAG(of),
        .AUX_CARRY_FLAG(af), .ZERO_FLAG(zf), .SIGN_FLAG(sf),
        .PARITY_FLAG(pf),
        .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WORD(),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .EXC_REQ(exc_req),
        .EXC_VECTOR(exc_vector), .EXC_INSTR_PTR(exc_ip));
    abx_mem_model mem_u (.clk(ref_clk), .rst(rst), .rd(mem_rd),
        .wr(mem_wr), .slow(slow), .addr(mem_addr), .wdata(mem_wdata),
        .rdata(mem_rdata), .ack(mem_ack));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction
    function automatic logic [15:0] exp_and(input logic [7:0] op);
        logic [15:0] r;
        case (op)
            8'h24, 8'h25: r = acc_val & imm;
            8'h80, 8'h81: r = rm_val & imm;
            8'h83: r = rm_val & sx(imm[7:0]);
            default: r = reg_val & rm_val;
        endcase
        return op[0] ? r : r & 16'h00FF;
    endfunction
    function automatic logic [6:0] flg(input logic [7:0] op);
        logic [15:0] r;
        logic [1:0] s;
        r = exp_and(op);
        s = op[7:1] == 7'h12 ? 2'h1 : op[7:1] == 7'h11 ? 2'h2 : 2'h3;
        return {1'b1, s, r == 16'h0000, op[0] ? r[15] : r[7], ~^r[7:0],
                op[0]};
    endfunction
    task automatic rnd();
        acc_val = 16'($urandom);
        reg_val = 16'($urandom);
        rm_val = 16'($urandom);
        imm = 16'($urandom);
        instr_ptr = 16'($urandom);
        eff_addr = {8'h00, 7'($urandom), 1'b0};
    endtask
    task automatic run(input logic [7:0] op, mr, input int n);
        int k;
        k = 0;
        @(posedge ref_clk);
        #1 {opcode, modrm, start} = {op, mr, 1'b1};
        @(posedge ref_clk);
        #1 start = 1'b0;
        while (done !== 1'b1 && k < 200) begin
            @(posedge ref_clk);
            #1 k++;
        end
        {exc_q, rwe_q, fwe_q, bad_q} = {exc_req, rwe, fwe, bad};
        `CHK(done, 1'b1)
        if (n >= 0) `CHK(k, n)
        $display("test op %h ended after %0d cycles", op, k);
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200000 miscompares++;
        summarize();
    end
    initial begin
        {rst, start, bus8, slow, opcode, modrm} = {4'h8, 16'h0000};
        {imm, acc_val, reg_val, rm_val, eff_addr, instr_ptr} = '0;
        void'($urandom(32'hFDF7));
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (i = 0; i < 27; i++) begin
            rnd();
            if (i >= 18) {acc_val, reg_val, rm_val} = '1;
            run(ops[i % 9], 8'hE0, cyc[i % 9]);
            `CHK(result, exp_and(ops[i % 9]))
            `CHK({cf, of}, 2'h0)
            `CHK({rwe_q, sel, zf, sf, pf, rw}, flg(ops[i % 9]))
        end
        for (i = 0; i < 9; i++) begin
            rnd();
            imm[7:0] = i < 3 ? 8'h80 : i < 6 ? 8'h7F : imm[7:0];
            old = i % 3 == 0 ? acc_val : rm_val;
            e = 5'({1'b0, old[3:0]} + {1'b0, imm[3:0]}) > 5'h0F;
            old = i % 3 == 2 ? old + sx(imm[7:0]) : old + imm[7:0];
            run(i % 3 == 0 ? 8'h04 : i % 3 == 1 ? 8'h80 : 8'h83, 8'hC0,
                i % 3 == 0 ? 3 : 4);
            `CHK(result, i % 3 == 2 ? old : old & 16'h00FF)
            `CHK(af, e)
        end
        for (i = 0; i < 4; i++) begin
            {bus8, slow} = {i == 1, i == 2};
            repeat (3) @(posedge ref_clk);
            rnd();
            old = 16'($urandom);
            mem_u.mem[eff_addr[8:1]] = old;
            run(i == 3 ? 8'h23 : 8'h21, 8'h04,
                i == 0 || i == 3 ? 10 : i == 1 ? 14 : -1);
            `CHK(i == 3 ? result : mem_u.mem[eff_addr[8:1]], reg_val & old)
        end
        for (i = 0; i < 6; i++) begin
            rnd();
            mem_u.mem[eff_addr[8:1]] = 16'hFF00;
            mem_u.mem[eff_addr[8:1] + 8'h01] = 16'h0100;
            reg_val = bidx[i];
            e = $signed(reg_val) < -256 || $signed(reg_val) > 256;
            run(8'h62, 8'h04, 33);
            `CHK(exc_q, e)
            if (e) `CHK({exc_vector, exc_ip}, {8'h05, instr_ptr})
            if (!e) `CHK({rwe_q, fwe_q}, 2'h0)
        end
        rnd();
        run(8'h80, 8'hC8, -1);
        `CHK({bad_q, rwe_q, fwe_q}, 3'h4)
        summarize();
    end
endmodule
